/* File: idc_pkg.sv */
// Purpose: shared constants and carriers for the I2C DAC slave control block
// Assumes: clk at 200 MHz, synchronous active-high reset
// Notes:   power-mode encodings and exit delay live here
package idc_pkg;

  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned EXIT_US_5V     = 14;
  localparam int unsigned EXIT_US_3V     = 17;
  localparam int unsigned EXIT_CYC_5V    = EXIT_US_5V * CLK_MHZ;
  localparam int unsigned EXIT_CYC_3V    = EXIT_US_3V * CLK_MHZ;

  localparam logic [4:0] ADDR_FIXED      = 5'h03;
  localparam logic [4:0] HS_MASTER_CODE  = 5'h01;
  localparam logic [15:0] WORD_RST       = 16'h0000;

  localparam int unsigned PM_POS         = 12;
  localparam int unsigned RSV_POS        = 14;

  localparam logic [1:0] STRAP_GND       = 2'h0;
  localparam logic [1:0] STRAP_VDD       = 2'h1;
  localparam logic [1:0] STRAP_OPEN      = 2'h2;

  typedef enum logic [1:0] {
    IDC_PM_NORMAL = 2'h0,
    IDC_PM_1K     = 2'h1,
    IDC_PM_100K   = 2'h2,
    IDC_PM_TRI    = 2'h3
  } idc_pm_e;

  typedef struct packed {
    logic amp_on;
    logic bias_on;
    logic string_on;
    logic term_1k;
    logic term_100k;
    logic out_valid;
  } idc_analog_s;

endpackage

/* File: idc_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: input asynchronous to clk
// Notes:   stage one is read only by stage two
`timescale 1ns/1ps
module idc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lv;
  } idc_sync_s;

  idc_sync_s st_ff;
  idc_sync_s nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.lv = st_ff.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lv: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.lv;

endmodule // idc_sync

/* File: idc_dac_ctrl.sv */
// Purpose: I2C slave control of a single-channel voltage DAC
// Assumes: scl/sda sampled by clk; SDA open drain, oe high pulls low
// Notes:   strap encoding per idc_pkg STRAP_* values
`timescale 1ns/1ps
module idc_dac_ctrl #(
  parameter int unsigned CODE_BITS = 12,
  parameter bit          SUPPLY_3V = 1'b0
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // I2C pins
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // Address strap
  input  wire logic [1:0]        addr_strap,
  // Analog control
  output logic [CODE_BITS-1:0]   dac_code,
  output idc_pkg::idc_analog_s   analog,
  output logic [1:0]             power_mode,
  output logic                   hs_mode
);

  // Only the three documented resolutions fit the left-justified word
  if (CODE_BITS != 8 && CODE_BITS != 10 && CODE_BITS != 12) begin : g_bad_code_bits
    $error("CODE_BITS must be 8, 10 or 12");
  end

  localparam int unsigned EXIT_CYC = SUPPLY_3V ? idc_pkg::EXIT_CYC_3V : idc_pkg::EXIT_CYC_5V;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_IGNORE
  } idc_st_e;

  typedef struct packed {
    idc_st_e      st;
    logic         scl_d;
    logic         sda_d;
    logic [7:0]   sh;
    logic [3:0]   bitn;
    logic         byten;
    logic [15:0]  word;
    logic [15:0]  rd_word;
    logic         rd_fresh;
    logic         hs;
    logic         drive_low;
    logic [1:0]   strap_ad;
    logic         strap_ok;
    logic [15:0]  exit_cnt;
  } idc_state_s;

  idc_state_s st_ff;
  idc_state_s nxt_st;
  logic       scl_s;
  logic       sda_s;

  idc_sync u_scl (.clk(clk), .sys_rst(sys_rst), .pin_in(scl_in), .level(scl_s));
  idc_sync u_sda (.clk(clk), .sys_rst(sys_rst), .pin_in(sda_in), .level(sda_s));

  // Strap decode to the two low address bits
  function automatic logic [1:0] strap_bits(input logic [1:0] s);
    unique case (s)
      idc_pkg::STRAP_GND:  strap_bits = 2'h3;
      idc_pkg::STRAP_VDD:  strap_bits = 2'h0;
      default:             strap_bits = 2'h2;
    endcase
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [1:0] pm;

  assign scl_rise = scl_s & ~st_ff.scl_d;
  assign scl_fall = ~scl_s & st_ff.scl_d;
  assign start_c  = scl_s & st_ff.scl_d & st_ff.sda_d & ~sda_s;
  assign stop_c   = scl_s & st_ff.scl_d & ~st_ff.sda_d & sda_s;
  assign pm       = st_ff.word[idc_pkg::PM_POS +: 2];

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.scl_d = scl_s;
    nxt_st.sda_d = sda_s;
    // Strap caught once after reset release
    if (!st_ff.strap_ok) begin
      nxt_st.strap_ad = strap_bits(addr_strap);
      nxt_st.strap_ok = 1'b1;
    end
    // Exit delay restarts on every return to normal
    if (pm != 2'(idc_pkg::IDC_PM_NORMAL)) begin
      nxt_st.exit_cnt = 16'(EXIT_CYC);
    end else if (st_ff.exit_cnt != 16'h0000) begin
      nxt_st.exit_cnt = st_ff.exit_cnt - 16'h0001;
    end
    if (stop_c) begin
      nxt_st.st        = ST_IDLE;
      nxt_st.hs        = 1'b0;
      nxt_st.drive_low = 1'b0;
    end else if (start_c) begin
      nxt_st.st        = ST_ADDR;
      nxt_st.bitn      = 4'h0;
      nxt_st.drive_low = 1'b0;
    end else if (scl_rise) begin
      unique case (st_ff.st)
        ST_ADDR, ST_WR: begin
          nxt_st.sh   = {st_ff.sh[6:0], sda_s};
          nxt_st.bitn = st_ff.bitn + 4'h1;
        end
        ST_RD: nxt_st.bitn = st_ff.bitn + 4'h1;
        ST_RD_ACK: begin
          // Master NACK ends the read
          if (sda_s || st_ff.byten) begin
            nxt_st.st = ST_IGNORE;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (st_ff.st)
        ST_ADDR: begin
          if (st_ff.bitn == 4'h8) begin
            if (st_ff.sh[7:3] == idc_pkg::HS_MASTER_CODE) begin
              nxt_st.hs = 1'b1;
              nxt_st.st = ST_IGNORE;
            end else if (st_ff.sh[7:1] == {idc_pkg::ADDR_FIXED, st_ff.strap_ad}) begin
              nxt_st.st        = ST_ADDR_ACK;
              nxt_st.drive_low = 1'b1;
            end else begin
              nxt_st.st = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          nxt_st.bitn  = 4'h0;
          nxt_st.byten = 1'b0;
          if (st_ff.sh[0]) begin
            nxt_st.st       = ST_RD;
            nxt_st.drive_low = ~st_ff.rd_word[15];
            nxt_st.rd_fresh = 1'b0;
            if (!st_ff.rd_fresh) begin
              nxt_st.rd_word   = 16'h0000;
              nxt_st.drive_low = 1'b1;
            end
          end else begin
            nxt_st.st        = ST_WR;
            nxt_st.drive_low = 1'b0;
          end
        end
        ST_WR: begin
          if (st_ff.bitn == 4'h8) begin
            nxt_st.st        = ST_WR_ACK;
            nxt_st.drive_low = 1'b1;
          end
        end
        ST_WR_ACK: begin
          nxt_st.drive_low = 1'b0;
          nxt_st.bitn      = 4'h0;
          if (!st_ff.byten) begin
            nxt_st.rd_word[15:8] = st_ff.sh;
            nxt_st.byten         = 1'b1;
            nxt_st.st            = ST_WR;
          end else begin
            // Commit only after second ack slot completes
            nxt_st.word     = {st_ff.rd_word[15:8], st_ff.sh};
            nxt_st.rd_word  = {st_ff.rd_word[15:8], st_ff.sh};
            nxt_st.rd_fresh = 1'b1;
            nxt_st.st       = ST_IGNORE;
          end
        end
        ST_RD: begin
          if (st_ff.bitn == 4'h8) begin
            nxt_st.st        = ST_RD_ACK;
            nxt_st.drive_low = 1'b0;
          end else begin
            nxt_st.drive_low = ~st_ff.rd_word[4'd15 - {1'b0, st_ff.bitn[2:0]} - (st_ff.byten ? 4'd8 : 4'd0)];
          end
        end
        ST_RD_ACK: begin
          nxt_st.byten     = 1'b1;
          nxt_st.bitn      = 4'h0;
          nxt_st.st        = ST_RD;
          nxt_st.drive_low = ~st_ff.rd_word[7];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '{st: ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, sh: 8'h00, bitn: 4'h0, byten: 1'b0,
                 word: idc_pkg::WORD_RST, rd_word: idc_pkg::WORD_RST, rd_fresh: 1'b0, hs: 1'b0,
                 drive_low: 1'b0, strap_ad: 2'h0, strap_ok: 1'b0, exit_cnt: 16'h0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe     = st_ff.drive_low;
  assign dac_code   = st_ff.word[11 -: CODE_BITS];
  assign power_mode = pm;
  assign hs_mode    = st_ff.hs;

  always_comb begin
    analog           = '0;
    analog.amp_on    = (pm == 2'(idc_pkg::IDC_PM_NORMAL));
    analog.bias_on   = analog.amp_on;
    analog.string_on = analog.amp_on;
    analog.term_1k   = (pm == 2'(idc_pkg::IDC_PM_1K));
    analog.term_100k = (pm == 2'(idc_pkg::IDC_PM_100K));
    analog.out_valid = analog.amp_on && (st_ff.exit_cnt == 16'h0000);
  end

endmodule // idc_dac_ctrl

/* File: idc_i2c_master.sv */
// Purpose: behavioural I2C master for the DAC slave bench
// Assumes: bench pulls SDA up
// Notes: SCL 64 ns, held high between frames
`timescale 1ns/1ps
module idc_i2c_master (
  // Bus lines
  output logic      scl = 1'b1,
  output logic      sda_drv = 1'b1,
  input  wire logic sda_bus
);
  // Start is cond(1,0), stop is cond(0,1)
  task automatic cond(input logic b, input logic e);
    sda_drv = b;
    #16 scl = 1'b1;
    #16 sda_drv = ~b;
    #16 scl = e;
    #16;
  endtask
  task automatic bit_io(input logic b, output logic v);
    sda_drv = b;
    #16 scl = 1'b1;
    #16 v = sda_bus;
    #16 scl = 1'b0;
    #16;
  endtask
  // Ack slot left released
  task automatic wr(input logic [7:0] x, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bit_io(x[i], v);
    bit_io(1'b1, v);
    ack = ~v;
  endtask
  task automatic rd(output logic [7:0] x);
    logic v;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, x[i]);
    bit_io(1'b0, v);
  endtask
endmodule // idc_i2c_master

/* File: idc_dac_ctrl_sva.sv */
// Purpose: port assertions for idc_dac_ctrl
// Assumes: one clock, sync active-high reset
// Notes: exit delay length is timed by the bench
`timescale 1ns/1ps
module idc_dac_ctrl_sva #(
  parameter int unsigned CODE_BITS = 12
) (
  // Clock and reset
  input logic                 clk,
  input logic                 sys_rst,
  // Pins and DAC controls
  input logic                 scl_in,
  input logic                 sda_in,
  input logic                 sda_oe,
  input logic [CODE_BITS-1:0] dac_code,
  input idc_pkg::idc_analog_s analog,
  input logic [1:0]           power_mode,
  input logic                 hs_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wake; $past(power_mode) != 2'h0 && power_mode == 2'h0; endsequence
  sequence s_quiet; !analog.out_valid [*8]; endsequence
  property p_norm; power_mode == 2'h0 |-> analog.amp_on && analog.bias_on && analog.string_on; endproperty
  property p_term; power_mode != 2'h0 |-> analog.term_1k == (power_mode == 2'h1)
    && analog.term_100k == (power_mode == 2'h2); endproperty
  property p_off; power_mode != 2'h0 |-> !(analog.amp_on || analog.bias_on || analog.string_on); endproperty
  property p_wake; s_wake |=> s_quiet; endproperty
  property p_rst; $past(sys_rst) |-> ~|dac_code && power_mode == 2'h0 && !hs_mode && !sda_oe; endproperty
  // Loads land in the SCL low phase after the last ack
  property p_load; $changed(dac_code) || $changed(power_mode) |-> !scl_in; endproperty
  property p_hs_nack; $rose(hs_mode) |-> !sda_oe [*8]; endproperty
  property p_hs_end; $fell(hs_mode) |-> scl_in && sda_in; endproperty
  a_norm: assert property (p_norm) else $error("normal mode off");
  a_term: assert property (p_term) else $error("bad termination");
  a_off: assert property (p_off) else $error("power-down still on");
  a_wake: assert property (p_wake) else $error("valid too early");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_load: assert property (p_load) else $error("load out of slot");
  a_hs_nack: assert property (p_hs_nack) else $error("master code acked");
  a_hs_end: assert property (p_hs_end) else $error("hs left without stop");
endmodule // idc_dac_ctrl_sva
bind idc_dac_ctrl idc_dac_ctrl_sva #(.CODE_BITS(CODE_BITS)) u_sva (.clk, .sys_rst, .scl_in, .sda_in, .sda_oe,
  .dac_code, .analog, .power_mode, .hs_mode);

/* File: idc_dac_ctrl_tb.sv */
// Purpose: self-checking bench for idc_dac_ctrl
// Assumes: 5 ns clk, 64 ns SCL
// Notes: one pass per strap value
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module idc_dac_ctrl_tb;
  logic        clk = 1'b0, sys_rst = 1'b1, k;
  logic [1:0]  addr_strap = 2'h0;
  logic [31:0] seed = 32'h3283B597, r;
  logic [15:0] w, d;
  logic [6:0]  a;
  int          failures = 0, n_checks = 0, n, q[$];
  wire         scl, sda_drv, sda_oe, hs_mode;
  wire [11:0]  dac_code;
  wire [1:0]   power_mode;
  wire         sda = sda_drv & ~sda_oe;
  idc_pkg::idc_analog_s analog;
  idc_dac_ctrl dut (.clk, .sys_rst, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe, .addr_strap, .dac_code,
    .analog, .power_mode, .hs_mode);
  idc_i2c_master m (.scl, .sda_drv, .sda_bus(sda));
  initial forever #2.5 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // About 30 us per pass, so 400 us means a hang
  initial begin
    #400000;
    failures++;
    finish_test();
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr_n(input logic [7:0] ab, input int nb);
    m.cond(1'b1, 1'b0);
    m.wr(ab, k);
    n = k;
    for (int i = 0; i < nb && k; i++) begin
      m.wr(w[15 - 8 * i -: 8], k);
      n += k;
    end
    m.cond(1'b0, 1'b1);
    if (n == 3) q = '{w, 0};
  endtask
  task automatic rd2();
    m.cond(1'b1, 1'b0);
    m.wr({a, 1'b1}, k);
    m.rd(d[15:8]);
    m.rd(d[7:0]);
    m.cond(1'b0, 1'b1);
    n = (q.size() > 0) ? q.pop_front() : 0;
    `CHK("rd_ack", 1'b1, k)
    `CHK("rd_word", n[15:0], d)
  endtask
  initial begin
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      addr_strap <= s[1:0];
      sys_rst <= 1'b1;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (12) @(posedge clk);
      // Keep every pin edge of the master off the rising clock edges
      #1.5;
      q = {};
      a = {5'h03, s == 0 ? 2'h3 : s == 1 ? 2'h0 : 2'h2};
      r = xs();
      w = {2'h0, s[1:0], r[11:0]};
      `CHK("rst_code", 12'h000, dac_code)
      wr_n({a ^ 7'h01, 1'b0}, 2);
      `CHK("bad_addr", 0, n)
      wr_n({a, 1'b0}, 1);
      `CHK("half_word", 12'h000, dac_code)
      wr_n({a, 1'b0}, 2);
      `CHK("acks", 3, n)
      `CHK("code", w[11:0], dac_code)
      `CHK("mode", s[1:0], power_mode)
      rd2();
      rd2();
      `CHK("held", w[11:0], dac_code)
      w[13:12] = 2'h0;
      wr_n({a, 1'b0}, 2);
      `CHK("exit", s == 0, analog.out_valid)
      repeat (3500) @(posedge clk);
      #1.5;
      `CHK("valid", 1'b1, analog.out_valid)
      m.cond(1'b1, 1'b0);
      m.wr({5'h01, r[14:12]}, k);
      `CHK("hs_nack", 1'b0, k)
      m.cond(1'b1, 1'b0);
      m.wr({a, 1'b0}, k);
      `CHK("hs_ack", 1'b1, k)
      `CHK("hs_on", 1'b1, hs_mode)
      m.cond(1'b0, 1'b1);
      repeat (10) @(posedge clk);
      `CHK("hs_off", 1'b0, hs_mode)
      $display("strap %0d done", s);
    end
    finish_test();
  end
endmodule // idc_dac_ctrl_tb
